/* pkg/phy_regmap_pkg.sv */
// constants for the paged register map of the one-port cable transceiver
package phy_regmap_pkg;

  // ****************************************************************
  // map geometry
  // ****************************************************************
  localparam int REG_COUNT = 16;
  localparam int BASE_COUNT = 8;
  localparam int PAGE_COUNT = 8;
  localparam int LIVE_PAGES = 3;
  localparam int MEM_DEPTH = LIVE_PAGES * BASE_COUNT;
  localparam int MEM_AW = 5;
  localparam int APB_AW = 8;
  // byte address of a register is four times its index
  localparam logic [APB_AW-1:0] MAP_END = 8'h40;

  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [3:0] IDX_NODE_ID_ROOT_POWER = 4'h0;
  localparam logic [3:0] IDX_HOLDOFF_RESET_GAP = 4'h1;
  localparam logic [3:0] IDX_EXTENSION_PORT_COUNT = 4'h2;
  localparam logic [3:0] IDX_SPEED_REPEATER_DELAY = 4'h3;
  localparam logic [3:0] IDX_LINK_CONTENDER_POWER = 4'h4;
  localparam logic [3:0] IDX_INTERRUPT_FEATURE_ENABLES = 4'h5;
  localparam logic [3:0] IDX_RESERVED_SIX = 4'h6;
  localparam logic [3:0] IDX_PAGE_AND_PORT_CHOICE = 4'h7;

  // ****************************************************************
  // fixed read values and field positions (bit 7 is the leftmost field)
  // ****************************************************************
  localparam logic [7:0] EXTENSION_PORT_COUNT_VAL = 8'hE1;
  localparam logic [7:0] SPEED_REPEATER_DELAY_VAL = 8'h40;
  localparam logic [2:0] JITTER_VAL = 3'h0;
  localparam int HOLDOFF_BIT = 7;
  localparam int BUS_RESET_REQ_BIT = 6;
  localparam int LINK_ACTIVE_BIT = 7;
  localparam int CONTENDER_BIT = 6;
  localparam int PAGE_LSB = 5;
  localparam int PORT_MSB = 3;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0] GAP_COUNT_RST = 6'h3F;
  localparam logic LINK_ACTIVE_RST = 1'b1;
  localparam logic CONTENDER_RST = 1'b0;
  localparam logic [2:0] POWER_CLASS_RST = 3'h0;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [2:0] PAGE_RST = 3'h0;
  localparam logic [3:0] PORT_RST = 4'h0;

  // only pages 0, 1 and 7 carry storage; 2 to 6 read as zero
  function automatic logic pageLive(input logic [2:0] page);
    pageLive = (page == 3'h0) || (page == 3'h1) || (page == 3'h7);
  endfunction

  // storage slot of a live page, followed by the paged offset
  function automatic logic [MEM_AW-1:0] pagedAddr(input logic [2:0] page,
                                                   input logic [2:0] offs);
    logic [1:0] slot;
    slot = (page == 3'h7) ? 2'h2 : {1'b0, page[0]};
    pagedAddr = {slot, offs};
  endfunction

endpackage

/* design/phy_page_mem.sv */
// storage for the paged registers of the live pages, registered read
`timescale 1ns/1ps
module phy_page_mem #(
  parameter int DEPTH = phy_regmap_pkg::MEM_DEPTH,
  parameter int AW = phy_regmap_pkg::MEM_AW
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // read port
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData,
  // write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData
);
  import phy_regmap_pkg::*;

  logic [7:0] mem_q [DEPTH];

  // small array, so a reset to zero is cheap and keeps reads defined
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (wrEn && (int'(wrAddr) < DEPTH)) begin
      mem_q[wrAddr] <= wrData;
    end
  end

  // read data from a register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 8'h00;
    end else if (rdEn) begin
      rdData <= (int'(rdAddr) < DEPTH) ? mem_q[rdAddr] : 8'h00;
    end
  end
endmodule // phy_page_mem

/* design/phy_base_regs.sv */
// writable fields of the fixed base registers
`timescale 1ns/1ps
module phy_base_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // write strobe from the bus side
  input wire logic wrEn,
  input wire logic [3:0] wrIndex,
  input wire logic [7:0] wrData,
  // bus reset from the arbiter
  input wire logic busReset,
  // field values
  output logic rootHoldoff,
  output logic busResetReq,
  output logic [5:0] gapCount,
  output logic linkActive,
  output logic contender,
  output logic [2:0] powerClass,
  output logic [7:0] eventEnables,
  output logic [2:0] pageSel,
  output logic [3:0] portSel
);
  import phy_regmap_pkg::*;

  wire wrHold = wrEn && (wrIndex == IDX_HOLDOFF_RESET_GAP);
  wire wrLink = wrEn && (wrIndex == IDX_LINK_CONTENDER_POWER);
  wire wrEnab = wrEn && (wrIndex == IDX_INTERRUPT_FEATURE_ENABLES);
  wire wrPage = wrEn && (wrIndex == IDX_PAGE_AND_PORT_CHOICE);

  // holdoff, bus reset request and gap; a write setting the request wins
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rootHoldoff <= 1'b0;
      busResetReq <= 1'b0;
      gapCount <= GAP_COUNT_RST;
    end else begin
      if (wrHold) begin
        rootHoldoff <= wrData[HOLDOFF_BIT];
        gapCount <= wrData[5:0];
      end
      if (wrHold && wrData[BUS_RESET_REQ_BIT]) begin
        busResetReq <= 1'b1;
      end else if (busReset || wrHold) begin
        busResetReq <= 1'b0;
      end
    end
  end

  // link, contender and power class; jitter stays read-only
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      linkActive <= LINK_ACTIVE_RST;
      contender <= CONTENDER_RST;
      powerClass <= POWER_CLASS_RST;
    end else if (wrLink) begin
      linkActive <= wrData[LINK_ACTIVE_BIT];
      contender <= wrData[CONTENDER_BIT];
      powerClass <= wrData[2:0];
    end
  end

  // event and feature enables
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      eventEnables <= ENABLES_RST;
    end else if (wrEnab) begin
      eventEnables <= wrData;
    end
  end

  // page and port choice; the reserved middle bit is never stored
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pageSel <= PAGE_RST;
      portSel <= PORT_RST;
    end else if (wrPage) begin
      pageSel <= wrData[PAGE_LSB+2:PAGE_LSB];
      portSel <= wrData[PORT_MSB:0];
    end
  end
endmodule // phy_base_regs

/* design/paged_phy_register_map.sv */
// APB slave holding the paged sixteen-register map of the cable transceiver
//
// Operation
// - Sixteen registers reachable by the link side, chosen by a four-bit index.
// - Indices zero to seven always reach the same base registers, any page.
// - Indices eight to fifteen reach one of eight pages by current page.
// - Page comes from the selector field of base register seven, set by writes.
// - Base register fields keep meaning and layout for every page value.
// - Reserved registers and fields read as zero.
// - Pages two through six make all eight paged indices reserved.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module paged_phy_register_map (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [phy_regmap_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // node status from the arbiter
  input wire logic [5:0] physicalId,
  input wire logic isRoot,
  input wire logic cablePowerOk,
  input wire logic busReset,
  // control fields to the arbiter
  output logic rootHoldoff,
  output logic busResetReq,
  output logic [5:0] gapCount,
  output logic linkActive,
  output logic contender,
  output logic [2:0] powerClass,
  output logic [7:0] eventEnables,
  output logic [2:0] pageSel,
  output logic [3:0] portSel
);
  import phy_regmap_pkg::*;

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic [7:0] memRdData;
  logic [7:0] baseView [BASE_COUNT];
  logic pready_q;
  logic pready_d;
  logic [7:0] rdByte_q;
  logic [7:0] rdByte_d;
  logic slvErr_q;
  logic slvErr_d;

  // index sits above the two byte bits; anything past the map errors
  wire [3:0] regIndex = paddr[5:2];
  wire inMap = (paddr < MAP_END);
  wire isPaged = regIndex[3];
  wire [2:0] regOffs = regIndex[2:0];
  // page taken only from the selector in base register seven
  wire pageOk = pageLive(pageSel);
  wire [MEM_AW-1:0] memAddr = pagedAddr(pageSel, regOffs);
  wire setupCyc = psel && !penable;
  wire doneCyc = psel && penable && pready_q;
  // byte lane 0 carries the whole register, so its strobe gates writes
  wire wrDone = doneCyc && pwrite && inMap && pstrb[0];
  wire baseWr = wrDone && !isPaged;
  wire memWr = wrDone && isPaged && pageOk;

  // ****************************************************************
  // base and paged storage
  // ****************************************************************
  // base fields do not look at the page at all
  phy_base_regs u_base (
    .clock(clock),
    .rst_b(rst_b),
    .wrEn(baseWr),
    .wrIndex(regIndex),
    .wrData(pwdata[7:0]),
    .busReset(busReset),
    .rootHoldoff(rootHoldoff),
    .busResetReq(busResetReq),
    .gapCount(gapCount),
    .linkActive(linkActive),
    .contender(contender),
    .powerClass(powerClass),
    .eventEnables(eventEnables),
    .pageSel(pageSel),
    .portSel(portSel)
  );

  // memory read starts in the setup cycle so data is ready one cycle later
  phy_page_mem #(
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW)
  ) u_pages (
    .clock(clock),
    .rst_b(rst_b),
    .rdEn(setupCyc),
    .rdAddr(memAddr),
    .rdData(memRdData),
    .wrEn(memWr),
    .wrAddr(memAddr),
    .wrData(pwdata[7:0])
  );

  // ****************************************************************
  // read views of the base registers
  // ****************************************************************
  // read-only and reserved bits are built from constants and status only
  assign baseView[0] = {physicalId, isRoot, cablePowerOk};
  assign baseView[1] = {rootHoldoff, busResetReq, gapCount};
  assign baseView[2] = EXTENSION_PORT_COUNT_VAL;
  assign baseView[3] = SPEED_REPEATER_DELAY_VAL;
  assign baseView[4] = {linkActive, contender, JITTER_VAL, powerClass};
  assign baseView[5] = eventEnables;
  assign baseView[6] = 8'h00;
  assign baseView[7] = {pageSel, 1'b0, portSel};

  // reserved pages read zero, whatever the storage holds
  assign rdByte_d = !inMap ? 8'h00 :
                    !isPaged ? baseView[regOffs] :
                    pageOk ? memRdData : 8'h00;
  assign pready_d = psel && penable && !pready_q;
  assign slvErr_d = pready_d && !inMap;

  // ****************************************************************
  // APB answer, one wait state
  // ****************************************************************
  // answer flops drive the ports directly
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      slvErr_q <= 1'b0;
      rdByte_q <= 8'h00;
    end else begin
      pready_q <= pready_d;
      slvErr_q <= slvErr_d;
      rdByte_q <= pready_d ? rdByte_d : 8'h00;
    end
  end

  assign pready = pready_q;
  assign pslverr = slvErr_q;
  assign prdata = {24'h000000, rdByte_q};

  // ****************************************************************
  // checks
  // ****************************************************************
  wire rdDone = doneCyc && !pwrite;

  // ****************************************************************
  // shadow of the last paged write
  // ****************************************************************
  logic [MEM_AW-1:0] lastAddr_q;
  logic [7:0] lastData_q;
  logic lastValid_q;

  // only the newest word is kept; older words are left to the bench read-back
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lastAddr_q <= {MEM_AW{1'b0}};
      lastData_q <= 8'h00;
      lastValid_q <= 1'b0;
    end else if (memWr) begin
      lastAddr_q <= memAddr;
      lastData_q <= pwdata[7:0];
      lastValid_q <= 1'b1;
    end
  end

  property p_unmapped_err;
    @(posedge clock) disable iff (!rst_b)
      rdDone || (doneCyc && pwrite) |-> (pslverr == !inMap);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("error answer does not match address range");

  property p_base_const;
    @(posedge clock) disable iff (!rst_b)
      rdDone && inMap && (regIndex == IDX_EXTENSION_PORT_COUNT) |->
        prdata[7:0] == 8'hE1;
  endproperty
  a_base_const: assert property (p_base_const)
    else $error("fixed base register read wrong value");

  property p_page_write;
    @(posedge clock) disable iff (!rst_b)
      wrDone && (regIndex == IDX_PAGE_AND_PORT_CHOICE) |=>
        pageSel == $past(pwdata[7:5]);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page selector did not follow write");

  property p_paged_rw;
    @(posedge clock) disable iff (!rst_b)
      rdDone && inMap && isPaged && pageOk && lastValid_q && (memAddr == lastAddr_q) |->
        prdata[7:0] == lastData_q;
  endproperty
  a_paged_rw: assert property (p_paged_rw)
    else $error("paged register read back differs from write");

  property p_gap_any_page;
    @(posedge clock) disable iff (!rst_b)
      rdDone && inMap && (regIndex == IDX_HOLDOFF_RESET_GAP) |->
        prdata[5:0] == gapCount;
  endproperty
  a_gap_any_page: assert property (p_gap_any_page)
    else $error("gap field read differs from stored value");

  property p_rsvd_zero;
    @(posedge clock) disable iff (!rst_b)
      rdDone && inMap && (regIndex == IDX_RESERVED_SIX ||
        regIndex == IDX_PAGE_AND_PORT_CHOICE) |-> prdata[31:8] == 24'h0 &&
        (regIndex == IDX_RESERVED_SIX ? prdata[7:0] == 8'h00 : !prdata[4]);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");

  property p_dead_pages;
    @(posedge clock) disable iff (!rst_b)
      rdDone && inMap && isPaged && !pageOk |-> prdata == 32'h0;
  endproperty
  a_dead_pages: assert property (p_dead_pages)
    else $error("reserved page read nonzero");

  property p_ro_ignored;
    @(posedge clock) disable iff (!rst_b)
      wrDone && (regIndex == IDX_NODE_ID_ROOT_POWER ||
        regIndex == IDX_RESERVED_SIX) |=> $stable(gapCount) &&
        $stable(pageSel) && $stable(eventEnables) && $stable(linkActive);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored)
    else $error("write to read-only register changed a field");

  property p_one_wait;
    @(posedge clock) disable iff (!rst_b)
      $rose(psel && penable) |-> !pready ##1 pready ##1 !pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("answer not after exactly one wait state");

  property p_strobe_gate;
    @(posedge clock) disable iff (!rst_b)
      doneCyc && pwrite && !pstrb[0] |=> $stable(eventEnables) && $stable(pageSel) &&
        $stable(gapCount) && $stable(linkActive);
  endproperty
  a_strobe_gate: assert property (p_strobe_gate)
    else $error("write with lane zero strobe low changed a field");

  property p_err_no_write;
    @(posedge clock) disable iff (!rst_b)
      doneCyc && pwrite && !inMap |=> $stable(eventEnables) && $stable(pageSel) &&
        $stable(gapCount) && $stable(linkActive);
  endproperty
  a_err_no_write: assert property (p_err_no_write)
    else $error("write past the map changed a field");

  property p_reg7_view;
    @(posedge clock) disable iff (!rst_b)
      rdDone && inMap && (regIndex == IDX_PAGE_AND_PORT_CHOICE) |->
        prdata[7:5] == pageSel && prdata[3:0] == portSel;
  endproperty
  a_reg7_view: assert property (p_reg7_view)
    else $error("page and port read differs from selector");

  property p_link_view;
    @(posedge clock) disable iff (!rst_b)
      rdDone && inMap && (regIndex == IDX_LINK_CONTENDER_POWER) |->
        prdata[7] == linkActive && prdata[6] == contender && prdata[5:3] == 3'h0 &&
        prdata[2:0] == powerClass;
  endproperty
  a_link_view: assert property (p_link_view)
    else $error("link and power read differs from fields");

  property p_status_view;
    @(posedge clock) disable iff (!rst_b)
      rdDone && inMap && (regIndex == IDX_NODE_ID_ROOT_POWER) |->
        prdata[7:2] == $past(physicalId) && prdata[1] == $past(isRoot) &&
        prdata[0] == $past(cablePowerOk);
  endproperty
  a_status_view: assert property (p_status_view)
    else $error("status read differs from status inputs");

  // answer lines stay quiet outside the one answer cycle
  property p_idle_quiet;
    @(posedge clock) disable iff (!rst_b)
      !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("read data or error shown outside the answer cycle");

  property p_req_clear;
    @(posedge clock) disable iff (!rst_b)
      busReset && !(baseWr && (regIndex == IDX_HOLDOFF_RESET_GAP) &&
        pwdata[BUS_RESET_REQ_BIT]) |=> !busResetReq;
  endproperty
  a_req_clear: assert property (p_req_clear)
    else $error("bus reset did not clear the reset request");
endmodule // paged_phy_register_map

/* bench/link_master_model.sv */
// apb master model standing in for the link-layer controller
`timescale 1ns/1ps
module link_master_model (
  // clock
  input wire logic clock,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [phy_regmap_pkg::APB_AW-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  // apb answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  import phy_regmap_pkg::*;

  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end

  // one transfer: setup, access held until pready, then release and one idle edge
  task automatic xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err,
                      output logic ok);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // one wait state puts the answer on the second access edge
    ok = (n == 2);
    psel <= 1'b0;
    penable <= 1'b0;
    // stale qualifiers inverted so the slave cannot lean on them
    pwrite <= ~wr;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clock);
  endtask
endmodule // link_master_model

/* bench/paged_phy_register_map_tb.sv */
// self-checking bench for the paged register map
`timescale 1ns/1ps
module paged_phy_register_map_tb;
  import phy_regmap_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic clock;
  logic rst_b = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [5:0] physicalId = 6'h2A;
  logic isRoot = 1'b1;
  logic cablePowerOk = 1'b0;
  logic busReset = 1'b0;
  logic rootHoldoff, busResetReq, linkActive, contender;
  logic [5:0] gapCount;
  logic [2:0] powerClass, pageSel;
  logic [7:0] eventEnables;
  logic [3:0] portSel;
  int n_fail = 0;
  int n_compared = 0;

  // ****************************************************************
  // instances
  // ****************************************************************
  paged_phy_register_map dut_u (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .physicalId(physicalId), .isRoot(isRoot),
    .cablePowerOk(cablePowerOk), .busReset(busReset), .rootHoldoff(rootHoldoff),
    .busResetReq(busResetReq), .gapCount(gapCount), .linkActive(linkActive),
    .contender(contender), .powerClass(powerClass), .eventEnables(eventEnables),
    .pageSel(pageSel), .portSel(portSel));
  link_master_model link_u (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one bus cycle; an answer later than one wait state counts as a mismatch
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s, input logic eErr, input logic [31:0] eRd);
    logic [31:0] rd;
    logic err, ok;
    link_u.xfer(wr, a, {24'h000000, d}, s, rd, err, ok);
    chk({31'h0, ok}, 32'h1);
    chk({31'h0, err}, {31'h0, eErr});
    if (!wr) chk(rd, eRd);
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    acc(1'b1, {2'b00, i, 2'b00}, d, 4'hF, 1'b0, 32'h0);
  endtask

  task automatic rc(input logic [3:0] i, input logic [7:0] e);
    acc(1'b0, {2'b00, i, 2'b00}, 8'h00, 4'h0, 1'b0, {24'h000000, e});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // base values straight after reset, reserved places zero
  task automatic t_reset();
    logic [7:0] e [8];
    e = '{8'hAA, 8'h3F, 8'hE1, 8'h40, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rc(4'(i), e[i]);
    rc(4'hF, 8'h00);
  endtask

  // writable, read-only and refused writes in the base block
  task automatic t_base();
    logic [7:0] e [8];
    e = '{8'hAA, 8'h95, 8'hE1, 8'h40, 8'hC7, 8'hA5, 8'h00, 8'h0F};
    for (int i = 0; i < 8; i++) wr(4'(i), (i == 1) ? 8'h95 : (i == 5) ? 8'hA5 : 8'hFF);
    wr(4'h7, 8'h1F);
    for (int i = 0; i < 8; i++) rc(4'(i), e[i]);
    chk({eventEnables, linkActive, gapCount, rootHoldoff, contender, powerClass, portSel},
        32'h00A5ABFF);
    acc(1'b1, 8'h14, 8'h00, 4'h0, 1'b0, 32'h0);
    acc(1'b1, 8'h40, 8'h00, 4'hF, 1'b1, 32'h0);
    acc(1'b0, 8'h40, 8'h00, 4'h0, 1'b1, 32'h0);
    acc(1'b0, 8'h17, 8'h00, 4'h0, 1'b0, 32'hA5);
  endtask

  // fill every page, then read all back: live pages keep apart, dead ones read zero
  task automatic t_pages();
    logic live;
    for (int p = 0; p < 8; p++) begin
      wr(4'h7, {3'(p), 5'h00});
      chk({29'h0, pageSel}, p);
      for (int o = 0; o < 8; o++) wr(4'(8 + o), {3'(p), 2'b10, 3'(o)});
    end
    for (int p = 7; p >= 0; p--) begin
      live = (p == 0) || (p == 1) || (p == 7);
      wr(4'h7, {3'(p), 5'h00});
      rc(4'h7, {3'(p), 5'h00});
      rc(4'h4, 8'hC7);
      rc(4'h5, 8'hA5);
      for (int o = 0; o < 8; o++) rc(4'(8 + o), live ? {3'(p), 2'b10, 3'(o)} : 8'h00);
    end
  endtask

  // status fields follow the inputs; bus reset drops the reset request
  task automatic t_status();
    physicalId <= 6'h15;
    isRoot <= 1'b0;
    cablePowerOk <= 1'b1;
    @(posedge clock);
    rc(4'h0, 8'h55);
    wr(4'h1, 8'h7F);
    rc(4'h1, 8'h7F);
    chk({31'h0, busResetReq}, 32'h1);
    busReset <= 1'b1;
    @(posedge clock);
    busReset <= 1'b0;
    @(posedge clock);
    chk({31'h0, busResetReq}, 32'h0);
    rc(4'h1, 8'h3F);
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // clock at 200 MHz
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // main sequence after twelve cycles of reset
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_reset();
    t_base();
    t_pages();
    t_status();
    test_done();
  end

  // watchdog well beyond the roughly eight hundred cycles the run needs
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule // paged_phy_register_map_tb
